// ==== design/audio_adc_interrupt_logic.sv ====
`timescale 1ns/10ps
`include "irq_map.svh"
module audio_adc_interrupt_logic #(
  parameter int PULSE_CYC = `IRQ_PULSE_MS * `IRQ_CLK_KHZ
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic asp_clk_err_evt,
  input wire logic pll_lock_evt,
  output logic irq_out_active_low
);
  irq_pkg::irq_state_s s_q;
  irq_pkg::irq_state_s s_d;
  irq_tmr_if tmr ();

  logic [7:0] evt;
  logic [7:0] unmasked;
  logic [7:0] shown;
  logic pending;
  logic fire;
  logic act;
  logic sel_cfg;
  logic sel_mask;
  logic sel_latch;
  irq_pkg::irq_mode_e mode;

  // ----------------------------------------
  // Decode and event gating
  // ----------------------------------------
  assign sel_cfg = reg_page == `IRQ_PAGE && reg_addr == `IRQ_CONFIG_ADDR;
  assign sel_mask = reg_page == `IRQ_PAGE && reg_addr == `IRQ_MASK_BANK_ADDR;
  assign sel_latch = reg_page == `IRQ_PAGE && reg_addr == `IRQ_LATCH_ADDR;
  assign mode = irq_pkg::irq_mode_e'(s_q.cfg[`IRQ_MODE_HI:`IRQ_MODE_LO]);

  always_comb begin
    evt = '0;
    evt[`IRQ_ASP_BIT] = asp_clk_err_evt;
    evt[`IRQ_PLL_BIT] = pll_lock_evt;
  end

  // A set mask bit hides its source from the pin.
  assign unmasked = s_q.latch & ~s_q.mask & `IRQ_SRC_MASK;
  assign pending = |unmasked;
  assign fire = |(evt & ~s_q.mask & `IRQ_SRC_MASK);
  assign shown = s_q.cfg[`IRQ_FILT_BIT] ? unmasked : (s_q.latch & `IRQ_SRC_MASK);

  // ----------------------------------------
  // Pulse timer
  // ----------------------------------------
  assign tmr.rpt = mode == irq_pkg::MODE_REPEAT;
  assign tmr.run = pending;
  assign tmr.kick = mode == irq_pkg::MODE_SINGLE && fire;

  if (PULSE_CYC < 2) begin : g_chk
    $error("PULSE_CYC must be at least 2");
  end

  irq_pulse_timer #(
    .PULSE_CYC(PULSE_CYC)
  ) u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .t(tmr)
  );

  // The reserved mode 1 is served as level mode so a bad write still signals events.
  always_comb begin
    case (mode)
      irq_pkg::MODE_REPEAT: act = pending && tmr.on;
      irq_pkg::MODE_SINGLE: act = tmr.on;
      irq_pkg::MODE_LEVEL: act = pending;
      default: act = pending;
    endcase
  end

  // ----------------------------------------
  // State update
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    if (reg_rd) begin
      s_d.rdata = 8'h00;
      if (sel_cfg) begin
        s_d.rdata = s_q.cfg & `IRQ_CONFIG_WMASK;
      end
      if (sel_mask) begin
        s_d.rdata = s_q.mask;
      end
      if (sel_latch) begin
        s_d.rdata = shown;
        s_d.latch = s_q.latch & ~shown;
      end
    end
    // Only the bits shown are cleared, so a hidden source keeps its capture.
    // A new event in the clearing cycle wins over the clear.
    s_d.latch = s_d.latch | evt;
    if (reg_wr && sel_cfg) begin
      s_d.cfg = reg_wdata & `IRQ_CONFIG_WMASK;
    end
    if (reg_wr && sel_mask) begin
      s_d.mask = reg_wdata;
    end
    s_d.pin = s_q.cfg[`IRQ_POL_BIT] ? act : !act;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.cfg <= `IRQ_CONFIG_RST;
      s_q.mask <= `IRQ_MASK_BANK_RST;
      s_q.latch <= `IRQ_LATCH_RST;
      s_q.rdata <= 8'h00;
      s_q.pin <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq_out_active_low = s_q.pin;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  AST_POL_LOW: assert property (
    (!s_q.cfg[`IRQ_POL_BIT] && mode == irq_pkg::MODE_LEVEL && pending && !reg_wr)
    |=> !irq_out_active_low)
    else $error("active-low pin not driven low");

  AST_POL_HIGH: assert property (
    (s_q.cfg[`IRQ_POL_BIT] && mode == irq_pkg::MODE_LEVEL && pending && !reg_wr)
    |=> irq_out_active_low)
    else $error("active-high pin not driven high");

  AST_LEVEL_HOLD: assert property (
    (s_q.cfg[`IRQ_POL_BIT] && mode == irq_pkg::MODE_LEVEL && pending
    && !reg_wr && !reg_rd)
    |=> irq_out_active_low ##1 irq_out_active_low)
    else $error("level mode pin dropped while pending");

  AST_REPEAT_ON: assert property (
    (mode == irq_pkg::MODE_REPEAT && pending && tmr.on && !s_q.cfg[`IRQ_POL_BIT]
    && !reg_wr)
    |=> !irq_out_active_low)
    else $error("repeat mode pulse missing");

  AST_REPEAT_OFF: assert property (
    (mode == irq_pkg::MODE_REPEAT && !tmr.on && !reg_wr)
    |=> irq_out_active_low != s_q.cfg[`IRQ_POL_BIT])
    else $error("repeat mode pin active in its quiet half");

  AST_SINGLE_FIRE: assert property (
    (mode == irq_pkg::MODE_SINGLE && fire && !reg_wr)
    |=> ##1 irq_out_active_low == $past(s_q.cfg[`IRQ_POL_BIT]))
    else $error("single pulse not started by unmasked event");

  AST_READ_ALL: assert property (
    (reg_rd && sel_latch && !s_q.cfg[`IRQ_FILT_BIT])
    |=> reg_rdata == ($past(s_q.latch) & `IRQ_SRC_MASK))
    else $error("unfiltered readback wrong");

  AST_READ_FILT: assert property (
    (reg_rd && sel_latch && s_q.cfg[`IRQ_FILT_BIT])
    |=> (reg_rdata & $past(s_q.mask)) == 8'h00)
    else $error("masked source visible in filtered readback");

  AST_FILT_KEEP: assert property (
    (reg_rd && sel_latch && s_q.cfg[`IRQ_FILT_BIT])
    |=> ($past(s_q.latch) & $past(s_q.mask) & `IRQ_SRC_MASK & ~s_q.latch) == 8'h00)
    else $error("filtered read cleared a hidden capture");

  AST_MASK_GATES: assert property (
    (s_q.latch[`IRQ_ASP_BIT] && !s_q.latch[`IRQ_PLL_BIT] && s_q.mask[`IRQ_ASP_BIT]
    && mode == irq_pkg::MODE_LEVEL && !reg_wr)
    |=> irq_out_active_low != s_q.cfg[`IRQ_POL_BIT])
    else $error("masked clock error reached the pin");

  AST_MASK_PLL: assert property (
    (s_q.latch[`IRQ_PLL_BIT] && !s_q.latch[`IRQ_ASP_BIT] && s_q.mask[`IRQ_PLL_BIT]
    && mode == irq_pkg::MODE_LEVEL && !reg_wr)
    |=> irq_out_active_low != s_q.cfg[`IRQ_POL_BIT])
    else $error("masked lock event reached the pin");

  AST_MASK_WRITE: assert property (
    (reg_wr && sel_mask) |=> s_q.mask == $past(reg_wdata))
    else $error("mask bank write lost");

  AST_ASP_SET: assert property (
    asp_clk_err_evt |=> s_q.latch[`IRQ_ASP_BIT])
    else $error("clock error not captured");

  AST_PLL_SET: assert property (
    pll_lock_evt |=> s_q.latch[`IRQ_PLL_BIT])
    else $error("lock event not captured");

  AST_SELF_CLEAR: assert property (
    (reg_rd && sel_latch && !s_q.cfg[`IRQ_FILT_BIT] && !asp_clk_err_evt && !pll_lock_evt)
    |=> (s_q.latch & `IRQ_SRC_MASK) == 8'h00)
    else $error("latch not cleared by read");

  AST_CFG_RSVD: assert property (
    (reg_rd && sel_cfg) |=> (reg_rdata & ~`IRQ_CONFIG_WMASK) == 8'h00)
    else $error("reserved config bits not zero");

  AST_RSVD_ZERO: assert property (
    (reg_rd && sel_latch) |=> (reg_rdata & ~`IRQ_SRC_MASK) == 8'h00)
    else $error("reserved latch bits not zero");

  AST_LATCH_RO: assert property (
    (reg_wr && sel_latch && !reg_rd && !asp_clk_err_evt && !pll_lock_evt)
    |=> $stable(s_q.latch))
    else $error("latch register changed by a write");

  AST_RDATA_HOLD: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  AST_IDLE_OFF: assert property (
    (!pending && mode == irq_pkg::MODE_LEVEL && !s_q.cfg[`IRQ_POL_BIT] && !reg_wr)
    |=> irq_out_active_low)
    else $error("pin active with nothing pending");

  AST_IDLE_ANY: assert property (
    (!pending && mode != irq_pkg::MODE_SINGLE && !reg_wr)
    |=> irq_out_active_low != s_q.cfg[`IRQ_POL_BIT])
    else $error("pin active in a latched mode with nothing pending");
endmodule // audio_adc_interrupt_logic

// ==== design/irq_map.svh ====
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

// ----------------------------------------
// Register map, page 0
// ----------------------------------------
`define IRQ_PAGE 8'h00
`define IRQ_CONFIG_ADDR 8'h32
`define IRQ_MASK_BANK_ADDR 8'h33
`define IRQ_LATCH_ADDR 8'h36
`define IRQ_CONFIG_RST 8'h00
`define IRQ_MASK_BANK_RST 8'hff
`define IRQ_LATCH_RST 8'h00
`define IRQ_CONFIG_WMASK 8'he4
`define IRQ_SRC_MASK 8'hc0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IRQ_POL_BIT 7
`define IRQ_MODE_HI 6
`define IRQ_MODE_LO 5
`define IRQ_FILT_BIT 2
`define IRQ_ASP_BIT 7
`define IRQ_PLL_BIT 6

// ----------------------------------------
// Timing
// ----------------------------------------
`define IRQ_PULSE_MS 2
`define IRQ_CLK_KHZ 20000

`endif

// ==== design/irq_pkg.sv ====
package irq_pkg;

  typedef enum logic [1:0] {
    MODE_LEVEL = 2'h0,
    MODE_RSVD = 2'h1,
    MODE_REPEAT = 2'h2,
    MODE_SINGLE = 2'h3
  } irq_mode_e;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] mask;
    logic [7:0] latch;
    logic [7:0] rdata;
    logic pin;
  } irq_state_s;

endpackage

// ==== design/irq_pulse_timer.sv ====
`timescale 1ns/10ps
`include "irq_map.svh"
module irq_pulse_timer #(
  parameter int PULSE_CYC = `IRQ_PULSE_MS * `IRQ_CLK_KHZ
) (
  input wire logic mclk,
  input wire logic rst_b,
  irq_tmr_if.tmr t
);
  localparam int CW = $clog2(2 * PULSE_CYC);
  localparam logic [CW-1:0] HALF = CW'(PULSE_CYC);
  localparam logic [CW-1:0] LAST = CW'(2 * PULSE_CYC - 1);

  if (PULSE_CYC < 2) begin : g_chk
    $error("PULSE_CYC must be at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic shot;
  } tmr_s;

  tmr_s s_q;
  tmr_s s_d;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // One counter serves both modes; the repeating phase restarts whenever the run level drops.
  always_comb begin
    s_d = s_q;
    if (t.rpt) begin
      s_d.shot = 1'b0;
      if (!t.run || s_q.cnt == LAST) begin
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end else if (t.kick) begin
      s_d.shot = 1'b1;
      s_d.cnt = '0;
    end else if (s_q.shot) begin
      s_d.cnt = s_q.cnt + 1'b1;
      if (s_q.cnt == HALF - 1'b1) begin
        s_d.shot = 1'b0;
      end
    end else begin
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign t.on = t.rpt ? (t.run && s_q.cnt < HALF) : s_q.shot;

  AST_SHOT_ENDS: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (s_q.shot && !t.kick && !t.rpt && s_q.cnt == HALF - 1'b1) |=> !s_q.shot)
    else $error("single pulse did not end after its length");
endmodule // irq_pulse_timer

// ==== design/irq_tmr_if.sv ====
`timescale 1ns/10ps
interface irq_tmr_if;
  logic run;
  logic kick;
  logic rpt;
  logic on;
  modport ctl (output run, output kick, output rpt, input on);
  modport tmr (input run, input kick, input rpt, output on);
endinterface

// ==== verification/irq_host_watch.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Host side watching the interrupt pin
// ----------------------------------------
module irq_host_watch (
  input wire logic mclk,
  input wire logic pin,
  input wire logic pol,
  input wire logic clr,
  output int act_cycles
);
  // The host counts cycles at the programmed active level, so pulse shapes are judged by length.
  always @(posedge mclk) begin
    if (clr) begin
      act_cycles <= 0;
    end else if (pin === pol) begin
      act_cycles <= act_cycles + 1;
    end
  end
endmodule // irq_host_watch

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
// ----------------------------------------
// Register and pin tests
// ----------------------------------------
module testbench;
  logic mclk = 0;
  logic rst_b = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_page = 8'h00;
  logic reg_wr = 0, reg_rd = 0, asp = 0, pll = 0, pol = 0, clr = 0;
  logic [7:0] reg_rdata;
  logic irq_pin;
  int err_count = 0, compares = 0, cyc = 0, n;
  // A short pulse count keeps the repeating and single modes within a few dozen cycles.
  audio_adc_interrupt_logic #(.PULSE_CYC(8)) u_audio_adc_interrupt_logic (.mclk(mclk),
    .rst_b(rst_b), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .asp_clk_err_evt(asp),
    .pll_lock_evt(pll), .irq_out_active_low(irq_pin));
  irq_host_watch u_irq_host_watch (.mclk(mclk), .pin(irq_pin), .pol(pol), .clr(clr),
    .act_cycles(n));
  initial begin
    forever #25 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 0;
    #1 `CHK("rdata", e, reg_rdata)
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic ev(input logic which);
    @(posedge mclk);
    asp <= which;
    pll <= !which;
    @(posedge mclk);
    asp <= 0;
    pll <= 0;
    settle();
  endtask
  task automatic pin_is(input logic e);
    `CHK("irq pin", e, irq_pin)
  endtask
  task automatic cnt(input logic fire, input int k, input int e);
    @(posedge mclk);
    clr <= 1;
    asp <= fire;
    @(posedge mclk);
    clr <= 0;
    asp <= 0;
    repeat (k) @(posedge mclk);
    #1 `CHK("active cycles", e, n)
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1;
    rd(8'h32, 8'h00);
    rd(8'h33, 8'hff);
    rd(8'h36, 8'h00);
    rd(8'h40, 8'h00);
    pin_is(1);
    $display("test done: reset values");
    wr(8'h32, 8'hff);
    rd(8'h32, 8'he4);
    wr(8'h36, 8'hff);
    rd(8'h36, 8'h00);
    wr(8'h32, 8'h00);
    $display("test done: access kinds");
    ev(1);
    pin_is(1);
    rd(8'h36, 8'h80);
    rd(8'h36, 8'h00);
    $display("test done: masked capture");
    wr(8'h32, 8'h04);
    ev(0);
    rd(8'h36, 8'h00);
    wr(8'h33, 8'hbf);
    settle();
    pin_is(0);
    rd(8'h36, 8'h40);
    settle();
    pin_is(1);
    $display("test done: filtered readback");
    wr(8'h33, 8'h3f);
    rd(8'h33, 8'h3f);
    wr(8'h32, 8'h80);
    pol <= 1;
    settle();
    pin_is(0);
    ev(1);
    pin_is(1);
    rd(8'h36, 8'h80);
    settle();
    pin_is(0);
    $display("test done: polarity");
    wr(8'h32, 8'h40);
    pol <= 0;
    ev(1);
    cnt(0, 32, 16);
    rd(8'h36, 8'h80);
    settle();
    pin_is(1);
    $display("test done: repeating mode");
    wr(8'h32, 8'h60);
    cnt(1, 40, 8);
    rd(8'h36, 8'h80);
    $display("test done: single mode");
    wr(8'h32, 8'h20);
    ev(1);
    pin_is(0);
    rd(8'h36, 8'h80);
    settle();
    pin_is(1);
    reg_page <= 8'h01;
    rd(8'h33, 8'h00);
    reg_page <= 8'h00;
    $display("test done: reserved mode and page decode");
    complete_run();
  end
endmodule // testbench
